// file: tb/host_bus_model.sv
// Purpose: Host processor driving the parallel bus in either style
// Assumes: Style input static between resets
// Notes:   Released address and data lines show the inverse of their last value; strobes and channel A select go high
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
    input  wire logic       ref_clk_i,
    input  wire logic       style_sel_i,
    input  wire logic [7:0] bus_i,
    output logic            read_strobe_n_o,
    output logic            write_strobe_n_o,
    output logic            channel_a_select_n_o,
    output logic            channel_b_select_n_o,
    output logic [2:0]      register_address_o,
    output logic [7:0]      data_o
);
    // Idle bus
    initial begin
        {read_strobe_n_o, write_strobe_n_o, channel_a_select_n_o, channel_b_select_n_o} = 4'hF;
        register_address_o = 3'h0;
        data_o = 8'h00;
    end
    // One whole access; the strobe rises at a falling edge, where read data is taken
    task automatic xfer(input logic rd, input logic ch, input logic [2:0] adr,
                        input logic [7:0] wd, output logic [7:0] q);
        @(negedge ref_clk_i);
        register_address_o = adr;
        data_o = wd;
        write_strobe_n_o = rd;
        read_strobe_n_o = !(rd && style_sel_i);
        channel_a_select_n_o = style_sel_i & ch;
        channel_b_select_n_o = style_sel_i ? !ch : ch;
        repeat (4) @(negedge ref_clk_i);
        q = bus_i;
        {read_strobe_n_o, write_strobe_n_o, channel_a_select_n_o} = 3'h7;
        channel_b_select_n_o = style_sel_i | !ch;
        register_address_o = ~adr;
        data_o = ~wd;
        repeat (2) @(negedge ref_clk_i);
    endtask
endmodule
`default_nettype wire

// file: tb/host_port_assertions.sv
// Purpose: Pin-level protocol checks for the host bus port
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound to every instance of the port
`timescale 1ns/10ps
`default_nettype none
module host_port_checker
    import host_port_pkg::*;
#(
    parameter int DW = DATA_W
) (
    input wire logic          ref_clk_i,
    input wire logic          rst_n_i,
    input wire logic          style_sel_i,
    input wire logic          read_strobe_n_i,
    input wire logic          write_strobe_n_i,
    input wire logic          channel_a_select_n_i,
    input wire logic          channel_b_select_n_i,
    input wire logic [2:0]    register_address_i,
    input wire logic [DW-1:0] data_bus_lines_i,
    input wire logic          data_bus_lines_oe_o,
    input wire reg_access_s   access_o,
    input wire logic          irq_a_i,
    input wire logic          irq_b_i,
    input wire logic          irq_oe_a_i,
    input wire logic          irq_oe_b_i,
    input wire logic          tx_room_a_i,
    input wire logic          rx_avail_a_i,
    input wire logic          irq_out_a_o,
    input wire logic          irq_out_a_oe_o,
    input wire logic          irq_out_b_o,
    input wire logic          irq_out_b_oe_o,
    input wire logic          aux_out_a_n_o,
    input wire logic          aux_out_b_n_o,
    input wire logic          tx_room_a_n_o,
    input wire logic          rx_avail_a_n_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic rq;
    logic wq;
    // Decoded read and write requests in either bus style
    always_comb begin
        rq = style_sel_i ? (!read_strobe_n_i && (channel_a_select_n_i ^ channel_b_select_n_i))
                         : (!channel_a_select_n_i && write_strobe_n_i);
        wq = style_sel_i ? (!write_strobe_n_i && (channel_a_select_n_i ^ channel_b_select_n_i))
                         : (!channel_a_select_n_i && !write_strobe_n_i);
    end
    a_read_start: assert property ($rose(rq) && !data_bus_lines_oe_o |=> access_o.rd
        && access_o.addr == $past(register_address_i)
        && access_o.chan_b == $past(style_sel_i ? channel_a_select_n_i : channel_b_select_n_i))
        else $error("read start not decoded");
    a_read_drive: assert property (access_o.rd && rq |=> data_bus_lines_oe_o)
        else $error("read data not driven");
    a_oe_release: assert property (data_bus_lines_oe_o && !rq |=> !data_bus_lines_oe_o)
        else $error("bus drive held after read");
    a_oe_cause: assert property (data_bus_lines_oe_o |-> $past(rq))
        else $error("bus driven without read");
    a_write_commit: assert property ($fell(wq) && $past(rst_n_i) |=> access_o.wr
        && access_o.wdata == $past(data_bus_lines_i, 2)) else $error("write not committed");
    a_write_cause: assert property (access_o.wr |-> $past(wq, 2) && !$past(wq))
        else $error("stray write");
    a_irq_a_route: assert property (style_sel_i && $past(rst_n_i) |-> irq_out_a_o == $past(irq_a_i)
        && irq_out_a_oe_o == $past(irq_oe_a_i) && aux_out_a_n_o == !$past(irq_oe_a_i))
        else $error("channel a interrupt routing wrong");
    a_irq_b_route: assert property (style_sel_i && $past(rst_n_i) |-> irq_out_b_o == $past(irq_b_i)
        && irq_out_b_oe_o == $past(irq_oe_b_i) && aux_out_b_n_o == !$past(irq_oe_b_i))
        else $error("channel b interrupt routing wrong");
    a_irq_shared: assert property (!style_sel_i && $past(rst_n_i) |-> !irq_out_a_o && !irq_out_b_o
        && irq_out_a_oe_o == $past(irq_a_i || irq_b_i) && irq_out_b_oe_o)
        else $error("shared interrupt wrong");
    a_status_out: assert property ($past(rst_n_i) |-> tx_room_a_n_o == !$past(tx_room_a_i)
        && rx_avail_a_n_o == !$past(rx_avail_a_i)) else $error("status outputs wrong");
endmodule
bind dual_style_host_bus_port host_port_checker #(.DW(DW)) chk (.*);
`default_nettype wire

// file: tb/test_dual_style_host_bus_port.sv
// Purpose: Self-checking bench for the host bus port in both styles
// Assumes: Register files modelled as fixed patterns per channel
// Notes:   Inputs change at falling edges
`timescale 1ns/10ps
`default_nettype none
module test_dual_style_host_bus_port;
    import host_port_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        style_sel_i = 1'b1;
    logic        irq_a_i = 1'b0, irq_b_i = 1'b0, irq_oe_a_i = 1'b0, irq_oe_b_i = 1'b0;
    logic        tx_room_a_i = 1'b0, rx_avail_a_i = 1'b0;
    logic        rs_n, ws_n, csa_n, csb_n, oe, ioa, ioa_oe, iob, iob_oe, aux_a_n, aux_b_n, tx_n, rx_n;
    logic [2:0]  adr;
    logic [7:0]  hdata, dout, bus, rdata_a, rdata_b;
    reg_access_s acc, last_rd, last_wr;
    int          n_mismatch = 0, cmp_count = 0, cyc = 0;
    // Clock, bus level and register file read data
    always #2.5 ref_clk_i = ~ref_clk_i;
    assign bus = oe ? dout : hdata;
    assign rdata_a = {4'hA, 1'b0, acc.addr};
    assign rdata_b = {4'hB, 1'b0, acc.addr};
    host_bus_model host (.ref_clk_i(ref_clk_i), .style_sel_i(style_sel_i), .bus_i(bus),
        .read_strobe_n_o(rs_n), .write_strobe_n_o(ws_n), .channel_a_select_n_o(csa_n),
        .channel_b_select_n_o(csb_n), .register_address_o(adr), .data_o(hdata));
    dual_style_host_bus_port DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .style_sel_i(style_sel_i),
        .read_strobe_n_i(rs_n), .write_strobe_n_i(ws_n), .channel_a_select_n_i(csa_n),
        .channel_b_select_n_i(csb_n), .register_address_i(adr), .data_bus_lines_i(bus),
        .data_bus_lines_o(dout), .data_bus_lines_oe_o(oe), .rdata_a_i(rdata_a), .rdata_b_i(rdata_b),
        .access_o(acc), .irq_a_i(irq_a_i), .irq_b_i(irq_b_i), .irq_oe_a_i(irq_oe_a_i),
        .irq_oe_b_i(irq_oe_b_i), .tx_room_a_i(tx_room_a_i), .rx_avail_a_i(rx_avail_a_i),
        .irq_out_a_o(ioa), .irq_out_a_oe_o(ioa_oe), .irq_out_b_o(iob), .irq_out_b_oe_o(iob_oe),
        .aux_out_a_n_o(aux_a_n), .aux_out_b_n_o(aux_b_n), .tx_room_a_n_o(tx_n), .rx_avail_a_n_o(rx_n));
    // Capture access pulses and cut a hang short; reset fills the captures with ones
    // so that a pulse missing in the second style cannot pass on a stale or zero value
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (rst_n_i !== 1'b1) begin
            last_rd <= '1;
            last_wr <= '1;
        end
        if (acc.rd === 1'b1) last_rd <= acc;
        if (acc.wr === 1'b1) last_wr <= acc;
        if (cyc == 3000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic restart(input logic s);
        @(negedge ref_clk_i);
        rst_n_i = 1'b0;
        style_sel_i = s;
        repeat (3) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
    endtask
    // Write then read both channels at the extreme register indexes
    task automatic t_bus();
        logic [7:0] q;
        for (int ch = 0; ch < 2; ch++) begin
            host.xfer(1'b0, ch[0], ch[0] ? 3'h7 : 3'h0, 8'h3C ^ 8'(ch), q);
            chk("write data", last_wr.wdata, 8'h3C ^ 8'(ch));
            chk("write place", {4'h0, last_wr.chan_b, last_wr.addr}, {4'h0, ch[0], ch[0] ? 3'h7 : 3'h0});
            host.xfer(1'b1, ch[0], ch[0] ? 3'h0 : 3'h7, 8'h00, q);
            chk("read data", q, {ch[0] ? 4'hB : 4'hA, 1'b0, ch[0] ? 3'h0 : 3'h7});
            chk("read place", {4'h0, last_rd.chan_b, last_rd.addr}, {4'h0, ch[0], ch[0] ? 3'h0 : 3'h7});
            chk("bus release", {7'h0, oe}, 8'h00);
        end
    endtask
    // Every combination of interrupt, enable and status inputs
    task automatic t_irq();
        for (int v = 0; v < 64; v++) begin
            {irq_a_i, irq_b_i, irq_oe_a_i, irq_oe_b_i, tx_room_a_i, rx_avail_a_i} = 6'(v);
            @(negedge ref_clk_i);
            chk("status", {6'h0, tx_n, rx_n}, {6'h0, !tx_room_a_i, !rx_avail_a_i});
            if (style_sel_i) begin
                chk("irq a", {5'h0, ioa, ioa_oe, aux_a_n}, {5'h0, irq_a_i, irq_oe_a_i, !irq_oe_a_i});
                chk("irq b", {5'h0, iob, iob_oe, aux_b_n}, {5'h0, irq_b_i, irq_oe_b_i, !irq_oe_b_i});
            end else begin
                chk("irq pins", {5'h0, ioa_oe ? ioa : 1'b1, iob, iob_oe}, {5'h0, !(irq_a_i | irq_b_i), 2'b01});
            end
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Strobe style first, then single-select style after a second reset
    initial begin
        restart(1'b1);
        t_bus();
        t_irq();
        restart(1'b0);
        t_bus();
        t_irq();
        close_out();
    end
endmodule
`default_nettype wire

// file: verilog/dual_style_host_bus_port.sv
// Purpose: Host parallel bus port of a two-channel serial controller
// Assumes: Host pins synchronous to ref_clk_i; register files lie outside
// Notes:   Strobe edges found by comparing two successive pin samples
//
// What this block does
// - Style input high selects separate strobes; low selects single select with direction.
// - Three address bits pick one register of the addressed channel.
// - Eight-bit two-way data bus: bytes in on writes, out on reads.
// - Strobe style: read strobe fall starts read, byte driven; host samples at strobe rise.
// - Write strobe fall starts write; byte captured at strobe rise.
// - Separate-strobe style has one low-active select per channel.
// - Single-select style: write strobe pin is direction, high read, low write.
// - Single-select style: channel A select is the one shared chip select.
// - Single-select style: channel B select pin is channel address bit.
// - Strobe style: channel A interrupt driven and aux low when enable bit set.
// - Strobe style: channel B interrupt and aux follow its enable bit likewise.
// - Single-select style: channel A interrupt pin is shared open-drain low interrupt.
// - Single-select style: channel B interrupt output held driven low.
// - Low-active transmit-ready output reflects channel A transmit status.
// - Low-active receive-ready output reflects channel A receive status.
`timescale 1ns/10ps
`default_nettype none
module dual_style_host_bus_port
    import host_port_pkg::*;
#(
    parameter int DW = DATA_W
) (
    // Clock and reset
    input  wire logic          ref_clk_i,
    input  wire logic          rst_n_i,
    // Host bus pins
    input  wire logic          style_sel_i,
    input  wire logic          read_strobe_n_i,
    input  wire logic          write_strobe_n_i,
    input  wire logic          channel_a_select_n_i,
    input  wire logic          channel_b_select_n_i,
    input  wire logic [2:0]    register_address_i,
    input  wire logic [DW-1:0] data_bus_lines_i,
    output logic      [DW-1:0] data_bus_lines_o,
    output logic               data_bus_lines_oe_o,
    // Register file side
    input  wire logic [DW-1:0] rdata_a_i,
    input  wire logic [DW-1:0] rdata_b_i,
    output reg_access_s        access_o,
    // Interrupt and status inputs
    input  wire logic          irq_a_i,
    input  wire logic          irq_b_i,
    input  wire logic          irq_oe_a_i,
    input  wire logic          irq_oe_b_i,
    input  wire logic          tx_room_a_i,
    input  wire logic          rx_avail_a_i,
    // Interrupt, aux and status pins
    output logic               irq_out_a_o,
    output logic               irq_out_a_oe_o,
    output logic               irq_out_b_o,
    output logic               irq_out_b_oe_o,
    output logic               aux_out_a_n_o,
    output logic               aux_out_b_n_o,
    output logic               tx_room_a_n_o,
    output logic               rx_avail_a_n_o
);

    // Whole port state, registered as one
    typedef struct packed {
        bus_state_e    state;
        logic          rd_q;        // Previous decoded read request
        logic          wr_q;        // Previous decoded write request
        logic          chan_b;      // Channel latched at cycle start
        logic [2:0]    addr;        // Register address latched at cycle start
        logic [DW-1:0] dout;
        logic          oe;
        reg_access_s   acc;
        logic          tx_n;
        logic          rx_n;
    } port_s;

    // Present state and its next value
    port_s st_reg;
    port_s st_next;

    // Decoded requests, high only while a channel is selected
    logic       rd_req;
    logic       wr_req;
    logic       sel_b;

    // Host pins gathered as one synchronous sample
    host_pins_s pins;

    assign pins = '{style_sel:          style_sel_i,
                    read_strobe_n:      read_strobe_n_i,
                    write_strobe_n:     write_strobe_n_i,
                    channel_a_select_n: channel_a_select_n_i,
                    channel_b_select_n: channel_b_select_n_i,
                    register_address:   register_address_i,
                    data_in:            DATA_W'(data_bus_lines_i)};

    // Decode the host pins per bus style; an unknown style makes no request
    always_comb begin
        case (pins.style_sel)
            STYLE_STROBES: begin
                sel_b  = ~pins.channel_b_select_n & pins.channel_a_select_n;
                rd_req = ~pins.read_strobe_n
                         & (pins.channel_a_select_n ^ pins.channel_b_select_n);
                wr_req = ~pins.write_strobe_n
                         & (pins.channel_a_select_n ^ pins.channel_b_select_n);
            end
            STYLE_SINGLE: begin
                // Read strobe is ignored here; the host keeps it high
                sel_b  = pins.channel_b_select_n;
                rd_req = ~pins.channel_a_select_n
                         & (pins.write_strobe_n == DIR_READ);
                wr_req = ~pins.channel_a_select_n
                         & (pins.write_strobe_n == DIR_WRITE);
            end
            default: begin
                sel_b  = 1'b0;
                rd_req = 1'b0;
                wr_req = 1'b0;
            end
        endcase
    end

    // Bus cycle sequencing
    always_comb begin
        st_next        = st_reg;
        st_next.rd_q   = rd_req;
        st_next.wr_q   = wr_req;
        st_next.acc.rd = 1'b0;
        st_next.acc.wr = 1'b0;
        st_next.tx_n   = ~tx_room_a_i;
        st_next.rx_n   = ~rx_avail_a_i;
        case (st_reg.state)
            ST_IDLE: begin
                // Wait for a fresh request edge
                st_next.oe = 1'b0;
                if (rd_req && !st_reg.rd_q) begin
                    st_next.state      = ST_READ;
                    st_next.chan_b     = sel_b;
                    st_next.addr       = pins.register_address;
                    st_next.acc.rd     = 1'b1;                             // Start internal read
                    st_next.acc.chan_b = sel_b;
                    st_next.acc.addr   = pins.register_address;
                end else if (wr_req && !st_reg.wr_q) begin
                    st_next.state     = ST_WRITE;
                    st_next.chan_b    = sel_b;
                    st_next.addr      = pins.register_address;
                    st_next.acc.wdata = pins.data_in;                      // A one-sample strobe still has data
                end
            end
            ST_READ: begin
                // Drive read data while the request stands
                st_next.dout = st_reg.chan_b ? rdata_b_i : rdata_a_i;
                st_next.oe   = rd_req;
                if (!rd_req) begin
                    st_next.state = ST_IDLE;
                end
            end
            ST_WRITE: begin
                // Track write data until the strobe rises
                if (!wr_req) begin
                    st_next.state      = ST_IDLE;                          // Capture at strobe rise
                    st_next.acc.wr     = 1'b1;
                    st_next.acc.chan_b = st_reg.chan_b;
                    st_next.acc.addr   = st_reg.addr;
                end else begin
                    st_next.acc.wdata  = pins.data_in;
                end
            end
            default: begin
                // Illegal state code returns to idle
                st_next.state = ST_IDLE;
                st_next.oe    = 1'b0;
            end
        endcase
    end

    // Register all state
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_reg.state  <= ST_IDLE;
            st_reg.rd_q   <= 1'b0;
            st_reg.wr_q   <= 1'b0;
            st_reg.chan_b <= 1'b0;
            st_reg.addr   <= ADDR_RST;
            st_reg.dout   <= DW'(DATA_RST);
            st_reg.oe     <= 1'b0;
            st_reg.acc    <= '0;
            st_reg.tx_n   <= 1'b1;
            st_reg.rx_n   <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs come straight from the state register
    assign data_bus_lines_o    = st_reg.dout;
    assign data_bus_lines_oe_o = st_reg.oe;
    assign access_o            = st_reg.acc;
    assign tx_room_a_n_o       = st_reg.tx_n;
    assign rx_avail_a_n_o      = st_reg.rx_n;

    // Interrupt and aux pin routing
    irq_pin_router u_irq (
        .ref_clk_i      (ref_clk_i),
        .rst_n_i        (rst_n_i),
        .style_sel_i    (style_sel_i),
        .irq_a_i        (irq_a_i),
        .irq_b_i        (irq_b_i),
        .irq_oe_a_i     (irq_oe_a_i),
        .irq_oe_b_i     (irq_oe_b_i),
        .irq_out_a_o    (irq_out_a_o),
        .irq_out_a_oe_o (irq_out_a_oe_o),
        .irq_out_b_o    (irq_out_b_o),
        .irq_out_b_oe_o (irq_out_b_oe_o),
        .aux_out_a_n_o  (aux_out_a_n_o),
        .aux_out_b_n_o  (aux_out_b_n_o)
    );

endmodule
`default_nettype wire

// file: verilog/host_port_pkg.sv
// Purpose: Shared types and constants for the dual-style host bus port
// Assumes: One 200 MHz clock, synchronous active-low reset
// Notes:   Pins are sampled synchronously; strobe edges are found by comparing samples
package host_port_pkg;

    localparam int          ADDR_W        = 3;
    localparam int          DATA_W        = 8;
    localparam int          REGS_PER_CH   = 8;
    localparam logic        STYLE_STROBES = 1'b1;   // Separate read and write strobes
    localparam logic        STYLE_SINGLE  = 1'b0;   // Single select with direction line
    localparam logic        DIR_READ      = 1'b1;
    localparam logic        DIR_WRITE     = 1'b0;
    localparam logic [7:0]  DATA_RST      = 8'h00;
    localparam logic [2:0]  ADDR_RST      = 3'h0;

    // Host-side pins, as sampled
    typedef struct packed {
        logic                  style_sel;
        logic                  read_strobe_n;
        logic                  write_strobe_n;
        logic                  channel_a_select_n;
        logic                  channel_b_select_n;
        logic [ADDR_W-1:0]     register_address;
        logic [DATA_W-1:0]     data_in;
    } host_pins_s;

    // One register access toward the channel register files
    typedef struct packed {
        logic                  rd;
        logic                  wr;
        logic                  chan_b;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     wdata;
    } reg_access_s;

    // Bus cycle states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_READ  = 3'b010,
        ST_WRITE = 3'b100
    } bus_state_e;

endpackage

// file: verilog/irq_pin_router.sv
// Purpose: Routes per-channel interrupts by bus style; aux outputs follow the enable bits in both styles
// Assumes: Inputs synchronous to ref_clk_i
// Notes:   All outputs registered; open-drain drive expressed as enables
`timescale 1ns/10ps
`default_nettype none
module irq_pin_router
    import host_port_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    input  wire logic style_sel_i,
    input  wire logic irq_a_i,
    input  wire logic irq_b_i,
    input  wire logic irq_oe_a_i,
    input  wire logic irq_oe_b_i,
    output logic      irq_out_a_o,
    output logic      irq_out_a_oe_o,
    output logic      irq_out_b_o,
    output logic      irq_out_b_oe_o,
    output logic      aux_out_a_n_o,
    output logic      aux_out_b_n_o
);

    typedef struct packed {
        logic a_o;
        logic a_oe;
        logic b_o;
        logic b_oe;
        logic aux_a_n;
        logic aux_b_n;
    } route_s;

    route_s st_reg;
    route_s st_next;

    // Pick pin drive per style and enable bits
    always_comb begin
        st_next         = st_reg;
        st_next.aux_a_n = ~irq_oe_a_i;
        st_next.aux_b_n = ~irq_oe_b_i;
        if (style_sel_i == STYLE_STROBES) begin
            st_next.a_o  = irq_a_i;
            st_next.a_oe = irq_oe_a_i;
            st_next.b_o  = irq_b_i;
            st_next.b_oe = irq_oe_b_i;
        end else begin
            st_next.a_o  = 1'b0;                 // Open drain pulls low only
            st_next.a_oe = irq_a_i | irq_b_i;
            st_next.b_o  = 1'b0;
            st_next.b_oe = 1'b1;
        end
    end

    // Register the pin state
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_reg <= '{a_o: 1'b0, a_oe: 1'b0, b_o: 1'b0, b_oe: 1'b0, aux_a_n: 1'b1, aux_b_n: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    assign irq_out_a_o    = st_reg.a_o;
    assign irq_out_a_oe_o = st_reg.a_oe;
    assign irq_out_b_o    = st_reg.b_o;
    assign irq_out_b_oe_o = st_reg.b_oe;
    assign aux_out_a_n_o  = st_reg.aux_a_n;
    assign aux_out_b_n_o  = st_reg.aux_b_n;

endmodule
`default_nettype wire
